// [vdls_pkg.sv]
package vdls_pkg;

  // window geometry
  localparam int unsigned VDLS_BASE_W = 20;
  localparam int unsigned VDLS_OFFS_W = 10;
  localparam logic [11:0] VDLS_BAR_MEM_SPEC = 12'h008;

  // register offsets, 12-bit byte offsets inside the window
  localparam logic [11:0] VDLS_OFF_DEVICE_STATUS = 12'h000;
  localparam logic [11:0] VDLS_OFF_CROP_EVEN = 12'h00c;
  localparam logic [11:0] VDLS_OFF_CROP_ODD = 12'h08c;

  // reset values
  localparam logic [7:0] VDLS_RST_DEVICE_STATUS = 8'h00;
  localparam logic [7:0] VDLS_RST_CROP = 8'h12;

  // device_status field positions
  localparam int unsigned VDLS_BIT_VIDEO_PRESENT = 7;
  localparam int unsigned VDLS_BIT_HORIZONTAL_LOCK = 6;
  localparam int unsigned VDLS_BIT_FIELD = 5;
  localparam int unsigned VDLS_BIT_LINE_COUNT_FORMAT = 4;
  localparam int unsigned VDLS_BIT_RESERVED = 3;
  localparam int unsigned VDLS_BIT_PLL_UNLOCKED = 2;
  localparam int unsigned VDLS_BIT_LUMA_OVERFLOW = 1;
  localparam int unsigned VDLS_BIT_CHROMA_OVERFLOW = 0;

  // status qualification counts
  localparam int unsigned VDLS_LOST_LINES = 31;
  localparam int unsigned VDLS_LOCK_LINES = 32;
  localparam int unsigned VDLS_FORMAT_FIELDS = 32;

  // line_count_format encodings
  localparam logic VDLS_FMT_525 = 1'b0;
  localparam logic VDLS_FMT_625 = 1'b1;

  // byte-lane zero mask for read data
  localparam logic [31:0] VDLS_LANE0_MASK = 32'h0000_00ff;

  // access phase of the target answer
  typedef enum logic [0:0] {
    VDLS_ST_IDLE = 1'b0,
    VDLS_ST_ANSWER = 1'b1
  } vdls_state_e;

endpackage : vdls_pkg

// [vdls_local_regs.sv]
`timescale 1ns/1ps
// Contract
// - decode local window accesses from address bits 11:2 and byte enables
// - register offset is 12 bits added to the programmed base, low bits zero
// - any combination of byte enables is accepted for read and write
// - local registers are accessible at any time, never busy
// - register data travels on byte lane 0 only, one byte per word
// - enabled upper lanes return zero on reads
// - unused window addresses are reserved, read value undefined
// - field-dependent registers have even and odd copies chosen by field
// - status register at offset zero resets to all zeros
// - both overflow flags stick until written or reset
// - the six other status bits are live, never latched
// - video present drops after 31 lines without sync, sets on sync
// - horizontal lock follows 32 consecutive hit or missed lines
// - writes to horizontal lock bit are ignored
// - field bit is 0 for odd field, 1 for even field
// - line format bit 0=525, 1=625, changes after 32 agreeing fields
// - pll unlocked bit reads 1 while pll out of lock
// - luma overflow bit is 0 after reset, set on luma overflow
// - chroma overflow bit is 0 after reset, set on chroma overflow
// - memory window is 4 kB, base bits 31:12 set by host
module vdls_local_regs
  import vdls_pkg::*;
#(
  parameter int unsigned LOST_LINES = VDLS_LOST_LINES,
  parameter int unsigned LOCK_LINES = VDLS_LOCK_LINES,
  parameter int unsigned FORMAT_FIELDS = VDLS_FORMAT_FIELDS
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [VDLS_BASE_W-1:0] i_bar_base,
  input wire logic i_acc_req,
  input wire logic i_acc_we,
  input wire logic [31:0] i_acc_addr,
  input wire logic [3:0] i_acc_be_n,
  input wire logic [31:0] i_acc_wdata,
  input wire logic i_line_strobe,
  input wire logic i_line_sync_seen,
  input wire logic i_line_hsync_on_time,
  input wire logic i_field_even,
  input wire logic i_field_end,
  input wire logic i_field_625,
  input wire logic i_pll_unlocked,
  input wire logic i_luma_adc_ovf,
  input wire logic i_chroma_adc_ovf,
  output logic o_acc_hit,
  output logic o_acc_ack,
  output logic [31:0] o_acc_rdata,
  output logic [11:0] o_bar_mem_spec,
  output logic [7:0] o_crop_active,
  output logic [7:0] o_device_status
);

  // counters are 6 bits wide; larger counts would need a wider counter
  localparam int unsigned CNT_W = 6;
  localparam logic [CNT_W-1:0] LOST_MAX = CNT_W'(LOST_LINES);
  localparam logic [CNT_W-1:0] LOCK_MAX = CNT_W'(LOCK_LINES);
  localparam logic [CNT_W-1:0] FMT_MAX = CNT_W'(FORMAT_FIELDS);

  // refuse counts that the counters cannot hold or that make no sense
  if (LOST_LINES < 1 || LOST_LINES > 63 ||
      LOCK_LINES < 1 || LOCK_LINES > 63 ||
      FORMAT_FIELDS < 1 || FORMAT_FIELDS > 63) begin : g_bad_counts
    $error("vdls_local_regs: qualification counts must be 1 to 63");
  end

  // saturating run counter step, shared by the three qualifiers
  function automatic logic [CNT_W-1:0] run_step(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] lim
  );
    logic [CNT_W-1:0] res;
    res = cnt;
    if (cnt < lim) begin
      res = cnt + CNT_W'(1);
    end
    return res;
  endfunction : run_step

  // pll lock and adc overflow come from the analog side: two flops each
  logic [1:0] pll_sync_r;
  logic [1:0] luma_sync_r;
  logic [1:0] chroma_sync_r;
  logic luma_prev_r;
  logic chroma_prev_r;
  logic pll_unlocked;
  logic luma_event;
  logic chroma_event;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pll_sync_r <= 2'h0;
      luma_sync_r <= 2'h0;
      chroma_sync_r <= 2'h0;
      luma_prev_r <= 1'b0;
      chroma_prev_r <= 1'b0;
    end else begin
      pll_sync_r <= {pll_sync_r[0], i_pll_unlocked};
      luma_sync_r <= {luma_sync_r[0], i_luma_adc_ovf};
      chroma_sync_r <= {chroma_sync_r[0], i_chroma_adc_ovf};
      luma_prev_r <= luma_sync_r[1];
      chroma_prev_r <= chroma_sync_r[1];
    end
  end

  // live pll state; overflow is caught on the rising edge of the level
  assign pll_unlocked = pll_sync_r[1];
  assign luma_event = luma_sync_r[1] & ~luma_prev_r;
  assign chroma_event = chroma_sync_r[1] & ~chroma_prev_r;

  // window decode: base match on 31:12, word offset from 11:2
  logic win_hit;
  logic [VDLS_OFFS_W-1:0] word_idx;
  logic lane0_en;
  logic wr_status;
  logic wr_crop_even;
  logic wr_crop_odd;

  assign win_hit = i_acc_req &&
                   (i_acc_addr[31:12] == i_bar_base);
  assign word_idx = i_acc_addr[11:2];
  assign lane0_en = ~i_acc_be_n[0];
  assign wr_status = win_hit && i_acc_we && lane0_en &&
                     (word_idx == VDLS_OFF_DEVICE_STATUS[11:2]);
  assign wr_crop_even = win_hit && i_acc_we && lane0_en &&
                        (word_idx == VDLS_OFF_CROP_EVEN[11:2]);
  assign wr_crop_odd = win_hit && i_acc_we && lane0_en &&
                       (word_idx == VDLS_OFF_CROP_ODD[11:2]);
  assign o_acc_hit = win_hit;
  assign o_bar_mem_spec = VDLS_BAR_MEM_SPEC;

  // video present: any sync line sets it, a run of lost lines clears it
  logic [CNT_W-1:0] lost_cnt_r;
  logic video_present_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      lost_cnt_r <= '0;
      video_present_r <= 1'b0;
    end else if (i_line_strobe) begin
      if (i_line_sync_seen) begin
        lost_cnt_r <= '0;
        video_present_r <= 1'b1;
      end else begin
        lost_cnt_r <= run_step(lost_cnt_r, LOST_MAX);
        if (run_step(lost_cnt_r, LOST_MAX) == LOST_MAX) begin
          video_present_r <= 1'b0;
        end
      end
    end
  end

  // horizontal lock: hysteresis on runs of on-time and late lines
  logic [CNT_W-1:0] hit_cnt_r;
  logic [CNT_W-1:0] miss_cnt_r;
  logic horizontal_lock_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      hit_cnt_r <= '0;
      miss_cnt_r <= '0;
      horizontal_lock_r <= 1'b0;
    end else if (i_line_strobe) begin
      if (i_line_hsync_on_time) begin
        miss_cnt_r <= '0;
        hit_cnt_r <= run_step(hit_cnt_r, LOCK_MAX);
        if (run_step(hit_cnt_r, LOCK_MAX) == LOCK_MAX) begin
          horizontal_lock_r <= 1'b1;
        end
      end else begin
        hit_cnt_r <= '0;
        miss_cnt_r <= run_step(miss_cnt_r, LOCK_MAX);
        if (run_step(miss_cnt_r, LOCK_MAX) == LOCK_MAX) begin
          horizontal_lock_r <= 1'b0;
        end
      end
    end
  end

  // line format: only a run of fields that disagree moves the bit
  logic [CNT_W-1:0] fmt_cnt_r;
  logic line_count_format_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      fmt_cnt_r <= '0;
      line_count_format_r <= VDLS_FMT_525;
    end else if (i_field_end) begin
      if (i_field_625 == line_count_format_r) begin
        fmt_cnt_r <= '0;
      end else if (run_step(fmt_cnt_r, FMT_MAX) == FMT_MAX) begin
        fmt_cnt_r <= '0;
        line_count_format_r <= i_field_625;
      end else begin
        fmt_cnt_r <= run_step(fmt_cnt_r, FMT_MAX);
      end
    end
  end

  // sticky overflow flags; a new event wins over a clearing write
  logic luma_overflow_r;
  logic chroma_overflow_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      luma_overflow_r <= VDLS_RST_DEVICE_STATUS[VDLS_BIT_LUMA_OVERFLOW];
      chroma_overflow_r <= VDLS_RST_DEVICE_STATUS[VDLS_BIT_CHROMA_OVERFLOW];
    end else begin
      if (luma_event) begin
        luma_overflow_r <= 1'b1;
      end else if (wr_status) begin
        luma_overflow_r <= 1'b0;
      end
      if (chroma_event) begin
        chroma_overflow_r <= 1'b1;
      end else if (wr_status) begin
        chroma_overflow_r <= 1'b0;
      end
    end
  end

  // assembled status byte; live bits are never stored here
  logic [7:0] status_now;

  always_comb begin
    status_now = VDLS_RST_DEVICE_STATUS;
    status_now[VDLS_BIT_VIDEO_PRESENT] = video_present_r;
    status_now[VDLS_BIT_HORIZONTAL_LOCK] = horizontal_lock_r;
    status_now[VDLS_BIT_FIELD] = i_field_even;
    status_now[VDLS_BIT_LINE_COUNT_FORMAT] = line_count_format_r;
    status_now[VDLS_BIT_RESERVED] = 1'b0;
    status_now[VDLS_BIT_PLL_UNLOCKED] = pll_unlocked;
    status_now[VDLS_BIT_LUMA_OVERFLOW] = luma_overflow_r;
    status_now[VDLS_BIT_CHROMA_OVERFLOW] = chroma_overflow_r;
  end

  // registered copy of the status for the status output port
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_device_status <= VDLS_RST_DEVICE_STATUS;
    end else begin
      o_device_status <= status_now;
    end
  end

  // even/odd copies of a field-switched capture register
  logic [7:0] crop_even_r;
  logic [7:0] crop_odd_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      crop_even_r <= VDLS_RST_CROP;
      crop_odd_r <= VDLS_RST_CROP;
    end else begin
      if (wr_crop_even) begin
        crop_even_r <= i_acc_wdata[7:0];
      end
      if (wr_crop_odd) begin
        crop_odd_r <= i_acc_wdata[7:0];
      end
    end
  end

  // the active copy follows the decoded field with no software action
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_crop_active <= VDLS_RST_CROP;
    end else begin
      o_crop_active <= i_field_even ? crop_even_r : crop_odd_r;
    end
  end

  // read mux; reserved words answer zero, which software must not trust
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (word_idx == VDLS_OFF_DEVICE_STATUS[11:2]) begin
      rd_byte = status_now;
    end else if (word_idx == VDLS_OFF_CROP_EVEN[11:2]) begin
      rd_byte = crop_even_r;
    end else if (word_idx == VDLS_OFF_CROP_ODD[11:2]) begin
      rd_byte = crop_odd_r;
    end
  end

  // answer phase: every hit is answered on the next edge, no wait states
  vdls_state_e state_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_r <= VDLS_ST_IDLE;
    end else if (win_hit) begin
      state_r <= VDLS_ST_ANSWER;
    end else begin
      state_r <= VDLS_ST_IDLE;
    end
  end

  assign o_acc_ack = (state_r == VDLS_ST_ANSWER);

  // read data: lane 0 only, upper lanes forced to zero whatever the enables
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_acc_rdata <= 32'h0000_0000;
    end else if (win_hit && !i_acc_we) begin
      o_acc_rdata <= {24'h00_0000, rd_byte} & VDLS_LANE0_MASK;
    end else if (win_hit) begin
      o_acc_rdata <= 32'h0000_0000; // writes return no data
    end
  end

endmodule : vdls_local_regs

// [vdls_local_regs_properties.sv]
`timescale 1ns/1ps
// port-level checks of the local register and status block
module vdls_local_regs_properties
  import vdls_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [VDLS_BASE_W-1:0] i_bar_base,
  input wire logic i_acc_req,
  input wire logic i_acc_we,
  input wire logic [31:0] i_acc_addr,
  input wire logic [3:0] i_acc_be_n,
  input wire logic i_field_even,
  input wire logic o_acc_hit,
  input wire logic o_acc_ack,
  input wire logic [31:0] o_acc_rdata,
  input wire logic [11:0] o_bar_mem_spec,
  input wire logic [7:0] o_device_status
);
  logic clr;
  logic [1:0] up_r;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // lane-0 write to the status word, the only thing that clears flags
  assign clr = o_acc_hit && i_acc_we && !i_acc_be_n[0]
    && i_acc_addr[11:2] == 10'h000;

  // edges since reset, since the status copy lags its inputs
  always_ff @(posedge i_mclk) begin
    if (i_rst) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end

  chk_hit_decode: assert property (o_acc_hit == (i_acc_req
    && i_acc_addr[31:12] == i_bar_base))
    else $error("hit does not follow the window decode");
  chk_ack_follows: assert property (o_acc_hit |=> o_acc_ack)
    else $error("no answer one cycle after a hit");
  chk_miss_silent: assert property (!o_acc_hit |=> !o_acc_ack)
    else $error("answer without a hit");
  chk_upper_zero: assert property (o_acc_ack |->
    o_acc_rdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  chk_rsvd_zero: assert property (o_device_status[3] == 1'b0)
    else $error("reserved status bit set");
  chk_bar_spec: assert property (o_bar_mem_spec == 12'h008)
    else $error("memory usage field wrong");
  chk_flags_sticky: assert property (!clr && !$past(clr) |=>
    (o_device_status[1:0] & $past(o_device_status[1:0]))
    == $past(o_device_status[1:0]))
    else $error("overflow flag dropped without a write");
  chk_field_live: assert property (up_r == 2'h3 &&
    $stable(i_field_even) && $past(i_field_even, 2) == i_field_even
    |-> o_device_status[5] == i_field_even)
    else $error("field bit does not follow the field");
endmodule : vdls_local_regs_properties

bind vdls_local_regs vdls_local_regs_properties u_props (.i_mclk, .i_rst,
  .i_bar_base, .i_acc_req, .i_acc_we, .i_acc_addr, .i_acc_be_n,
  .i_field_even, .o_acc_hit, .o_acc_ack, .o_acc_rdata, .o_bar_mem_spec,
  .o_device_status);

// [vdls_host_model.sv]
`timescale 1ns/1ps
// host bus master issuing one target access at a time
module vdls_host_model (
  input wire logic i_mclk,
  input wire logic i_ack,
  input wire logic [31:0] i_rdata,
  output logic o_req,
  output logic o_we,
  output logic [31:0] o_addr,
  output logic [3:0] o_be_n,
  output logic [31:0] o_wdata
);
  initial {o_req, o_we, o_addr, o_be_n, o_wdata} = '0;

  // one-edge request, then a bounded wait for the answer
  task automatic access(input logic we, input logic [31:0] addr,
      input logic [3:0] be_n, input logic [31:0] wd,
      output logic [31:0] rd, output logic got);
    @(posedge i_mclk);
    o_req <= 1'b1;
    o_we <= we;
    o_addr <= addr;
    o_be_n <= be_n;
    o_wdata <= wd;
    @(posedge i_mclk);
    // released address and write data lines show the inverse so stale values never pass
    o_req <= 1'b0;
    o_addr <= ~addr;
    o_wdata <= ~wd;
    got = 1'b0;
    rd = 32'h0;
    for (int n = 0; n < 4 && !got; n++) begin
      @(posedge i_mclk);
      got = (i_ack === 1'b1);
      rd = i_rdata;
    end
  endtask : access
endmodule : vdls_host_model

// [vdls_local_regs_bench.sv]
`timescale 1ns/1ps
module vdls_local_regs_bench;
  // short counts keep the qualification runs quick
  localparam int N = 3;
  logic i_mclk, i_rst, i_acc_req, i_acc_we, i_line_strobe, i_line_sync_seen;
  logic i_line_hsync_on_time, i_field_even, i_field_end, i_field_625;
  logic i_pll_unlocked, i_luma_adc_ovf, i_chroma_adc_ovf, o_acc_hit, o_acc_ack;
  logic [19:0] i_bar_base;
  logic [31:0] i_acc_addr, i_acc_wdata, o_acc_rdata, rd;
  logic [3:0] i_acc_be_n;
  logic [11:0] o_bar_mem_spec;
  logic [7:0] o_crop_active, o_device_status, v0, v1;
  logic video_present, horizontal_lock, fmt, luma, chroma, got;
  int lost_n, hit_n, miss_n, fmt_n, n_fail, checks_done, cyc;

  always #5 i_mclk = ~i_mclk;

  vdls_local_regs #(.LOST_LINES(N), .LOCK_LINES(N), .FORMAT_FIELDS(N)) dut (
    .i_mclk, .i_rst, .i_bar_base, .i_acc_req, .i_acc_we, .i_acc_addr,
    .i_acc_be_n, .i_acc_wdata, .i_line_strobe, .i_line_sync_seen,
    .i_line_hsync_on_time, .i_field_even, .i_field_end, .i_field_625,
    .i_pll_unlocked, .i_luma_adc_ovf, .i_chroma_adc_ovf, .o_acc_hit,
    .o_acc_ack, .o_acc_rdata, .o_bar_mem_spec, .o_crop_active,
    .o_device_status);

  vdls_host_model host (.i_mclk, .i_ack(o_acc_ack), .i_rdata(o_acc_rdata),
    .o_req(i_acc_req), .o_we(i_acc_we), .o_addr(i_acc_addr),
    .o_be_n(i_acc_be_n), .o_wdata(i_acc_wdata));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic rw(input logic we, input logic [11:0] off,
      input logic [3:0] be_n, input logic [31:0] wd);
    host.access(we, {i_bar_base, off}, be_n, wd, rd, got);
    chk({31'h0, got}, 32'h1);
  endtask : rw

  // settle past the input synchronisers, then compare against the model
  task automatic rd_status;
    repeat (3) @(posedge i_mclk);
    rw(1'b0, 12'h000, 4'h0, 32'h0);
    chk(rd, {24'h0, video_present, horizontal_lock, i_field_even, fmt, 1'b0, i_pll_unlocked,
      luma, chroma});
  endtask : rd_status

  task automatic line(input logic s, input logic t);
    @(posedge i_mclk);
    {i_line_strobe, i_line_sync_seen, i_line_hsync_on_time} <= {1'b1, s, t};
    @(posedge i_mclk);
    i_line_strobe <= 1'b0;
    lost_n = s ? 0 : lost_n + 1;
    if (s) video_present = 1'b1;
    else if (lost_n >= N) video_present = 1'b0;
    hit_n = t ? hit_n + 1 : 0;
    miss_n = t ? 0 : miss_n + 1;
    if (hit_n >= N) horizontal_lock = 1'b1;
    if (miss_n >= N) horizontal_lock = 1'b0;
  endtask : line

  task automatic field(input logic f);
    @(posedge i_mclk);
    {i_field_end, i_field_625} <= {1'b1, f};
    @(posedge i_mclk);
    i_field_end <= 1'b0;
    fmt_n = (f == fmt) ? 0 : fmt_n + 1;
    if (fmt_n >= N) {fmt, fmt_n} = {f, 32'h0};
  endtask : field

  // hang guard, far above the expected run length
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      report_and_stop;
    end
  end

  initial begin
    {i_mclk, i_rst, i_line_strobe, i_line_sync_seen, i_line_hsync_on_time,
      i_field_even, i_field_end, i_field_625, i_pll_unlocked,
      i_luma_adc_ovf, i_chroma_adc_ovf} = 11'h200;
    {video_present, horizontal_lock, fmt, luma, chroma} = 5'h00;
    i_bar_base = 20'($urandom(64));
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    chk({24'h0, o_crop_active}, 32'h12);
    rd_status;
    for (int i = 0; i < 60; i++) begin
      line(1'($urandom), 1'($urandom));
      rd_status;
    end
    for (int i = 0; i < 16; i++) begin
      i_field_even <= 1'($urandom);
      field(1'($urandom % 3 != 0));
      rd_status;
    end
    i_luma_adc_ovf <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_luma_adc_ovf <= 1'b0;
    luma = 1'b1;
    rd_status;
    i_chroma_adc_ovf <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_chroma_adc_ovf <= 1'b0;
    chroma = 1'b1;
    rd_status;
    rw(1'b1, 12'h000, 4'h1, 32'($urandom));
    rd_status;
    rw(1'b1, 12'h000, 4'hE, 32'($urandom));
    {luma, chroma} = 2'h0;
    rd_status;
    i_pll_unlocked <= 1'b1;
    rd_status;
    i_pll_unlocked <= 1'b0;
    rw(1'b1, 12'h000, 4'hE, 32'h0000_0004);
    rd_status;
    v0 = 8'($urandom);
    v1 = 8'($urandom);
    rw(1'b1, 12'h00C, 4'($urandom) & 4'hE, {24'($urandom), v0});
    rw(1'b1, 12'h08C, 4'hE, {24'h0, v1});
    rw(1'b0, 12'h00C, 4'($urandom), 32'h0);
    chk(rd, {24'h0, v0});
    i_field_even <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk({24'h0, o_crop_active}, {24'h0, v0});
    i_field_even <= 1'b0;
    repeat (3) @(posedge i_mclk);
    chk({24'h0, o_crop_active}, {24'h0, v1});
    rw(1'b0, 12'hFFC, 4'h0, 32'h0);
    host.access(1'b0, {~i_bar_base, 12'h000}, 4'h0, 32'h0, rd, got);
    chk({31'h0, got}, 32'h0);
    // leave a flag set so the mid-run reset has something to clear
    i_luma_adc_ovf <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_luma_adc_ovf <= 1'b0;
    // second reset in mid-run clears flags, counters and copies
    i_rst <= 1'b1;
    @(posedge i_mclk);
    i_rst <= 1'b0;
    {video_present, horizontal_lock, fmt, luma, chroma} = 5'h00;
    {lost_n, hit_n, miss_n, fmt_n} = '0;
    // the reset lands in the nba region of that edge, so look one edge on
    @(posedge i_mclk);
    chk({24'h0, o_crop_active}, 32'h12);
    rd_status;
    report_and_stop;
  end
endmodule : vdls_local_regs_bench
